// [verilog/fces_pkg.sv]
// Package: command codes, states and counts for the erase-suspend sequencer
package fces_pkg;
    // Command byte encodings
    localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
    localparam logic [7:0] CMD_WORD_PROG_A = 8'h10;
    localparam logic [7:0] CMD_WORD_PROG_B = 8'h40;
    localparam logic [7:0] CMD_BUF_PROG = 8'hE8;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0] CMD_FACTORY_SETUP = 8'h80;
    localparam logic [7:0] CMD_CONFIRM = 8'hD0;
    localparam logic [7:0] CMD_SUSPEND = 8'hB0;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_READ_ID = 8'h90;
    localparam logic [7:0] CMD_READ_QUERY = 8'h98;
    localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
    localparam logic [7:0] CMD_LOCK_CONFIRM = 8'h01;
    localparam logic [7:0] CMD_LOCKDOWN_CONFIRM = 8'h2F;
    localparam logic [7:0] CMD_UNLOCK_CONFIRM = 8'hD0;
    localparam logic [7:0] CMD_CFG_CONFIRM = 8'h03;
    // Factory load word count
    localparam logic [5:0] FACTORY_LOAD_WORDS = 6'h20;
    // Sequencer states
    typedef enum logic [3:0] {
        ST_READY,
        ST_ERASE_SUSP,
        ST_WP_SETUP_ES,
        ST_WP_BUSY_ES,
        ST_WP_SUSP_ES,
        ST_BUF_SETUP_ES,
        ST_BUF_LOAD1_ES,
        ST_BUF_LOAD2_ES,
        ST_BUF_CONF_ES,
        ST_BUF_BUSY_ES,
        ST_BUF_SUSP_ES,
        ST_LOCK_SETUP_ES,
        ST_FBP_SETUP,
        ST_FBP_LOAD,
        ST_FBP_BUSY
    } fces_state_t;
endpackage

// [verilog/fces_seq.sv]
// Command sequencer for nested operations while a block erase is suspended
// Operation
// - Decode the documented command byte set
// - Doubly suspended word program ignores most commands
// - Buffered program: setup, load1, load2, confirm
// - Confirm starts busy; others error out
// - Buffered busy suspends only on suspend
// - Buffered suspend resumes only on confirm
// - Bad lock confirm returns with lock error
// - Factory setup confirm loads words until a foreign block address
module fces_seq (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic WR_STB,          // One-cycle bus write strobe
    input wire logic [15:0] WR_DATA,  // Bus write data, command in low byte
    input wire logic [15:0] WR_BLOCK, // Block address of the write
    input wire logic ERASE_SUSPENDED, // Erase suspend entered elsewhere
    input wire logic [5:0] BUF_COUNT, // Buffered fill count from first load
    input wire logic OP_DONE,         // write_state_machine operation complete
    output fces_pkg::fces_state_t STATE,
    output logic ERR_FLAG,            // Program/sequence error, sticky
    output logic LOCK_ERR,            // Lock error, sticky
    output logic START_WP,            // One-cycle start of word program
    output logic START_BUF,           // One-cycle start of buffered program
    output logic SUSPEND_REQ,         // One-cycle suspend request
    output logic RESUME_REQ,          // One-cycle resume request
    output logic FBP_DATA_STB,        // Factory data word accepted
    output logic [15:0] FBP_DATA      // Factory data word
);
    // Command class decode, used by the buffered confirm state
    function automatic logic is_cmd(input logic [7:0] c);
        is_cmd = (c == fces_pkg::CMD_READ_ARRAY) || (c == fces_pkg::CMD_WORD_PROG_A)
              || (c == fces_pkg::CMD_WORD_PROG_B) || (c == fces_pkg::CMD_BUF_PROG)
              || (c == fces_pkg::CMD_ERASE_SETUP) || (c == fces_pkg::CMD_FACTORY_SETUP);
    endfunction

    // Valid lock-type confirm after a lock setup
    function automatic logic is_lock_conf(input logic [7:0] c);
        is_lock_conf = (c == fces_pkg::CMD_LOCK_CONFIRM) || (c == fces_pkg::CMD_CFG_CONFIRM)
                    || (c == fces_pkg::CMD_LOCKDOWN_CONFIRM)
                    || (c == fces_pkg::CMD_UNLOCK_CONFIRM);
    endfunction

    fces_pkg::fces_state_t state_reg, state_next; // Sequencer state
    logic err_reg, err_next;                       // Sticky error
    logic lerr_reg, lerr_next;                     // Sticky lock error
    logic [5:0] cnt_reg, cnt_next;                 // Words still to load
    logic [15:0] blk_reg, blk_next;                // Block given at setup
    logic [15:0] fdat_reg, fdat_next;              // Factory data word
    logic fstb_reg, fstb_next;                     // Factory data strobe
    logic [7:0] cmd;                               // Command byte

    assign cmd = WR_DATA[7:0];

    // Next-state logic for the whole sequencer
    always_comb begin
        state_next = state_reg;
        err_next = err_reg;
        lerr_next = lerr_reg;
        cnt_next = cnt_reg;
        blk_next = blk_reg;
        fdat_next = fdat_reg;
        fstb_next = 1'b0;
        START_WP = 1'b0;
        START_BUF = 1'b0;
        SUSPEND_REQ = 1'b0;
        RESUME_REQ = 1'b0;
        case (state_reg)
            fces_pkg::ST_READY, fces_pkg::ST_ERASE_SUSP: begin
                // Entry points; the rest of the machine lives elsewhere
                if (WR_STB) begin
                    if (cmd == fces_pkg::CMD_CLEAR_STATUS) begin
                        err_next = 1'b0;
                        lerr_next = 1'b0;
                    end
                    if (ERASE_SUSPENDED || state_reg == fces_pkg::ST_ERASE_SUSP) begin
                        if (cmd == fces_pkg::CMD_WORD_PROG_A || cmd == fces_pkg::CMD_WORD_PROG_B)
                            state_next = fces_pkg::ST_WP_SETUP_ES;
                        else if (cmd == fces_pkg::CMD_BUF_PROG)
                            state_next = fces_pkg::ST_BUF_SETUP_ES;
                        else if (cmd == fces_pkg::CMD_LOCK_SETUP)
                            state_next = fces_pkg::ST_LOCK_SETUP_ES;
                        else
                            state_next = fces_pkg::ST_ERASE_SUSP;
                    end else if (cmd == fces_pkg::CMD_FACTORY_SETUP) begin
                        blk_next = WR_BLOCK;
                        state_next = fces_pkg::ST_FBP_SETUP;
                    end
                end else if (ERASE_SUSPENDED) begin
                    state_next = fces_pkg::ST_ERASE_SUSP;
                end
            end
            fces_pkg::ST_WP_SETUP_ES: begin
                // Any write is the program data
                if (WR_STB) begin
                    state_next = fces_pkg::ST_WP_BUSY_ES;
                    START_WP = 1'b1;
                end
            end
            fces_pkg::ST_WP_BUSY_ES: begin
                // Completion has priority over a same-cycle suspend
                if (OP_DONE) begin
                    state_next = fces_pkg::ST_ERASE_SUSP;
                end else if (WR_STB && cmd == fces_pkg::CMD_SUSPEND) begin
                    state_next = fces_pkg::ST_WP_SUSP_ES;
                    SUSPEND_REQ = 1'b1;
                end
            end
            fces_pkg::ST_WP_SUSP_ES: begin
                // Only resume leaves the double suspension
                if (WR_STB && cmd == fces_pkg::CMD_CONFIRM) begin
                    state_next = fces_pkg::ST_WP_BUSY_ES;
                    RESUME_REQ = 1'b1;
                end else begin
                    state_next = fces_pkg::ST_WP_SUSP_ES;
                end
            end
            fces_pkg::ST_BUF_SETUP_ES: begin
                if (WR_STB)
                    state_next = fces_pkg::ST_BUF_LOAD1_ES;
            end
            fces_pkg::ST_BUF_LOAD1_ES: begin
                // First load carries the word count
                if (WR_STB) begin
                    cnt_next = BUF_COUNT;
                    state_next = fces_pkg::ST_BUF_LOAD2_ES;
                end
            end
            fces_pkg::ST_BUF_LOAD2_ES: begin
                // Count runs to zero, then confirm is awaited
                if (WR_STB) begin
                    if (cnt_reg == 6'h00)
                        state_next = fces_pkg::ST_BUF_CONF_ES;
                    else
                        cnt_next = cnt_reg - 6'h01;
                end
            end
            fces_pkg::ST_BUF_CONF_ES: begin
                if (WR_STB) begin
                    if (cmd == fces_pkg::CMD_CONFIRM) begin
                        state_next = fces_pkg::ST_BUF_BUSY_ES;
                        START_BUF = 1'b1;
                    end else if (is_cmd(cmd)) begin
                        state_next = fces_pkg::ST_ERASE_SUSP;
                        err_next = 1'b1;
                    end else begin
                        state_next = fces_pkg::ST_READY;
                        err_next = 1'b1;
                    end
                end
            end
            fces_pkg::ST_BUF_BUSY_ES: begin
                if (OP_DONE) begin
                    state_next = fces_pkg::ST_ERASE_SUSP;
                end else if (WR_STB && cmd == fces_pkg::CMD_SUSPEND) begin
                    state_next = fces_pkg::ST_BUF_SUSP_ES;
                    SUSPEND_REQ = 1'b1;
                end
            end
            fces_pkg::ST_BUF_SUSP_ES: begin
                if (WR_STB && cmd == fces_pkg::CMD_CONFIRM) begin
                    state_next = fces_pkg::ST_BUF_BUSY_ES;
                    RESUME_REQ = 1'b1;
                end
            end
            fces_pkg::ST_LOCK_SETUP_ES: begin
                // Lock itself is handled elsewhere; bad confirm flags here
                if (WR_STB) begin
                    state_next = fces_pkg::ST_ERASE_SUSP;
                    if (!is_lock_conf(cmd))
                        lerr_next = 1'b1;
                end
            end
            fces_pkg::ST_FBP_SETUP: begin
                if (WR_STB) begin
                    if (cmd == fces_pkg::CMD_CONFIRM) begin
                        cnt_next = fces_pkg::FACTORY_LOAD_WORDS - 6'h01;
                        state_next = fces_pkg::ST_FBP_LOAD;
                    end else begin
                        state_next = fces_pkg::ST_READY;
                        err_next = 1'b1;
                    end
                end
            end
            fces_pkg::ST_FBP_LOAD, fces_pkg::ST_FBP_BUSY: begin
                // Every write to the setup block is data; foreign block address ends the mode
                if (WR_STB) begin
                    if (WR_BLOCK == blk_reg) begin
                        fdat_next = WR_DATA;
                        fstb_next = 1'b1;
                        cnt_next = cnt_reg - 6'h01;
                        state_next = fces_pkg::ST_FBP_BUSY;
                    end else begin
                        state_next = fces_pkg::ST_READY;
                    end
                end
            end
            default: state_next = fces_pkg::ST_READY;
        endcase
    end

    // State registers
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            state_reg <= fces_pkg::ST_READY;
            err_reg <= 1'b0;
            lerr_reg <= 1'b0;
            cnt_reg <= 6'h00;
            blk_reg <= 16'h0000;
            fdat_reg <= 16'h0000;
            fstb_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            err_reg <= err_next;
            lerr_reg <= lerr_next;
            cnt_reg <= cnt_next;
            blk_reg <= blk_next;
            fdat_reg <= fdat_next;
            fstb_reg <= fstb_next;
        end
    end

    assign STATE = state_reg;
    assign ERR_FLAG = err_reg;
    assign LOCK_ERR = lerr_reg;
    assign FBP_DATA = fdat_reg;
    assign FBP_DATA_STB = fstb_reg;

    // Checks beside the sequencer
    wp_setup_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        state_reg == fces_pkg::ST_WP_SETUP_ES && WR_STB |=> state_reg == fces_pkg::ST_WP_BUSY_ES)
        else $error("word program setup did not go busy");
    wp_dbl_susp_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        state_reg == fces_pkg::ST_WP_SUSP_ES && !(WR_STB && cmd == fces_pkg::CMD_CONFIRM)
        |=> state_reg == fces_pkg::ST_WP_SUSP_ES)
        else $error("double suspend left without resume");
    sequence buf_load1_s;
        state_reg == fces_pkg::ST_BUF_LOAD1_ES && WR_STB;
    endsequence
    buf_load_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        buf_load1_s |=> state_reg == fces_pkg::ST_BUF_LOAD2_ES)
        else $error("buffered load one did not advance");
    buf_conf_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        state_reg == fces_pkg::ST_BUF_CONF_ES && WR_STB && cmd != fces_pkg::CMD_CONFIRM
        |=> err_reg && state_reg != fces_pkg::ST_BUF_BUSY_ES)
        else $error("bad buffered confirm not flagged");
    buf_susp_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        state_reg == fces_pkg::ST_BUF_BUSY_ES && !OP_DONE && WR_STB
        && cmd == fces_pkg::CMD_SUSPEND |=> state_reg == fces_pkg::ST_BUF_SUSP_ES)
        else $error("buffered busy did not suspend");
    buf_resume_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        state_reg == fces_pkg::ST_BUF_SUSP_ES && WR_STB && cmd == fces_pkg::CMD_CONFIRM
        |-> RESUME_REQ ##1 state_reg == fces_pkg::ST_BUF_BUSY_ES)
        else $error("buffered suspend did not resume");
    lock_err_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        state_reg == fces_pkg::ST_LOCK_SETUP_ES && WR_STB && !is_lock_conf(cmd)
        |=> lerr_reg && state_reg == fces_pkg::ST_ERASE_SUSP)
        else $error("bad lock confirm not flagged");
    fbp_count_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        state_reg == fces_pkg::ST_FBP_SETUP && WR_STB && cmd == fces_pkg::CMD_CONFIRM
        |=> cnt_reg == fces_pkg::FACTORY_LOAD_WORDS - 6'h01)
        else $error("factory load count wrong");
    fbp_data_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        state_reg == fces_pkg::ST_FBP_BUSY && WR_STB && WR_BLOCK == blk_reg
        |=> FBP_DATA_STB && FBP_DATA == $past(WR_DATA))
        else $error("factory data not taken");
    done_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (state_reg == fces_pkg::ST_WP_BUSY_ES || state_reg == fces_pkg::ST_BUF_BUSY_ES)
        && OP_DONE |=> state_reg == fces_pkg::ST_ERASE_SUSP)
        else $error("completion did not return to erase suspend");
endmodule

// [dv/fces_host.sv]
// Host model: issues command and data writes on the bus
module fces_host (
    input wire logic mclk,
    output logic wr_stb,
    output logic [15:0] wr_data,
    output logic [15:0] wr_block
);
    timeunit 1ns;
    timeprecision 1ps;
    // Bus idle at time zero
    initial begin
        wr_stb = 1'b0;
        wr_data = 16'h5A5A;
        wr_block = 16'hA5A5;
    end
    // One write held across one edge; codes, loads, factory data
    task automatic wr(input logic [15:0] d, input logic [15:0] b);
        wr_stb = 1'b1;
        wr_data = d;
        wr_block = b;
        @(posedge mclk);
        #1;
    endtask
    // Release; floating lines invert so stale data never looks valid
    task automatic idle(input int n);
        wr_stb = 1'b0;
        wr_data = ~wr_data;
        wr_block = ~wr_block;
        repeat (n) begin
            @(posedge mclk);
            #1;
        end
    endtask
endmodule

// [dv/flash_cmd_fsm_erase_suspend_tb.sv]
// Self-checking bench for the erase-suspend command sequencer
module flash_cmd_fsm_erase_suspend_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // Expected outcome of one write or completion
    typedef struct {
        fces_pkg::fces_state_t st;
        logic err;
        logic lck;
        logic [3:0] pul;
        logic fbp;
        logic [15:0] dat;
    } fces_note_t;
    localparam fces_pkg::fces_state_t ES = fces_pkg::ST_ERASE_SUSP;
    localparam fces_pkg::fces_state_t RDY = fces_pkg::ST_READY;
    logic mclk = 1'b0;
    logic rst_n;
    logic wr_stb;
    logic [15:0] wr_data;
    logic [15:0] wr_block;
    logic erase_susp;
    logic [5:0] buf_count;
    logic op_done;
    fces_pkg::fces_state_t state;
    logic err_flag;
    logic lock_err;
    logic [3:0] pul;
    logic fbp_stb;
    logic [15:0] fbp_dat;
    int fail_count = 0;
    int n_checks = 0;
    fces_note_t q[$];
    fces_note_t n;
    logic pend = 1'b0;
    logic [3:0] pul_cap;
    logic exp_err;
    logic exp_lck;
    logic [15:0] blk;
    logic [5:0] k;
    // Commands that change nothing in a suspended state; suspend last
    logic [7:0] cmds [12] = '{8'hFF, 8'h10, 8'h40, 8'hE8, 8'h20, 8'h80,
                              8'h70, 8'h50, 8'h90, 8'h98, 8'h60, 8'hB0};
    logic [7:0] okc [4] = '{8'h01, 8'h2F, 8'hD0, 8'h03};
    always #5 mclk = ~mclk;
    fces_host u_host (.mclk(mclk), .wr_stb(wr_stb), .wr_data(wr_data), .wr_block(wr_block));
    fces_seq u_dut (.MCLK(mclk), .RST_N(rst_n), .WR_STB(wr_stb), .WR_DATA(wr_data),
        .WR_BLOCK(wr_block), .ERASE_SUSPENDED(erase_susp), .BUF_COUNT(buf_count),
        .OP_DONE(op_done), .STATE(state), .ERR_FLAG(err_flag), .LOCK_ERR(lock_err),
        .START_WP(pul[3]), .START_BUF(pul[2]), .SUSPEND_REQ(pul[1]), .RESUME_REQ(pul[0]),
        .FBP_DATA_STB(fbp_stb), .FBP_DATA(fbp_dat));
    // One comparison, counted
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask
    // Verdict and end of run
    task automatic test_done;
        if (fail_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Monitor: half a cycle after each taken write or completion, oldest note
    always @(negedge mclk) begin
        if (pend) begin
            if (q.size() == 0) begin
                chk("note queue", 16'h1, 16'h0);
            end else begin
                n = q.pop_front();
                chk("data strobe", 16'(n.fbp), 16'(fbp_stb));
                if (n.fbp) begin
                    chk("fbp state", 16'h1, 16'(state === fces_pkg::ST_FBP_LOAD ||
                        state === fces_pkg::ST_FBP_BUSY));
                    chk("fbp data", n.dat, fbp_dat);
                end else begin
                    chk("state", 16'(n.st), 16'(state));
                    chk("pulses", 16'(n.pul), 16'(pul_cap));
                end
                chk("error", 16'(n.err), 16'(err_flag));
                chk("lock error", 16'(n.lck), 16'(lock_err));
            end
        end
        // Pulses are combinational: capture them while the write is on the bus
        pend = wr_stb | op_done;
        pul_cap = pul;
    end
    // Command write with random upper byte, plus its note
    task automatic cmd(input logic [7:0] c, input fces_pkg::fces_state_t s,
                       input logic [3:0] p);
        logic [15:0] d;
        d = {8'($urandom), c};
        q.push_back(fces_note_t'{s, exp_err, exp_lck, p, 1'b0, d});
        u_host.wr(d, blk);
    endtask
    // Factory data word, expected back on the data port
    task automatic fdat(input logic [15:0] d);
        q.push_back(fces_note_t'{RDY, exp_err, exp_lck, 4'h0, 1'b1, d});
        u_host.wr(d, blk);
    endtask
    // One-cycle operation-complete with bus idle
    task automatic done(input fces_pkg::fces_state_t s);
        u_host.idle(0);
        q.push_back(fces_note_t'{s, exp_err, exp_lck, 4'h0, 1'b0, 16'h0000});
        op_done = 1'b1;
        @(posedge mclk);
        #1;
        op_done = 1'b0;
    endtask
    // Main sequence
    initial begin
        void'($urandom(32'h52A70166));
        rst_n = 1'b0;
        erase_susp = 1'b1;
        buf_count = 6'h00;
        op_done = 1'b0;
        exp_err = 1'b0;
        exp_lck = 1'b0;
        blk = 16'h0003;
        repeat (3) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        chk("reset state", 16'(RDY), 16'(state));
        u_host.idle(2);
        chk("suspend entry", 16'(ES), 16'(state));
        // Word program nested in erase suspend
        cmd(8'h40, fces_pkg::ST_WP_SETUP_ES, 4'h0);
        cmd(8'($urandom), fces_pkg::ST_WP_BUSY_ES, 4'h8);
        cmd(8'hB0, fces_pkg::ST_WP_SUSP_ES, 4'h2);
        foreach (cmds[i]) cmd(cmds[i], fces_pkg::ST_WP_SUSP_ES, 4'h0);
        cmd(8'hD0, fces_pkg::ST_WP_BUSY_ES, 4'h1);
        done(ES);
        // Buffered program: busy path, then both error exits of confirm
        for (int r = 0; r < 3; r++) begin
            k = 6'($urandom_range(3));
            buf_count = k;
            // Level is ignored once suspended, so let it wander here
            erase_susp = 1'($urandom);
            cmd(8'hE8, fces_pkg::ST_BUF_SETUP_ES, 4'h0);
            cmd(8'($urandom), fces_pkg::ST_BUF_LOAD1_ES, 4'h0);
            cmd(8'($urandom), fces_pkg::ST_BUF_LOAD2_ES, 4'h0);
            for (int i = 0; i <= k; i++)
                cmd(8'($urandom), i == k ? fces_pkg::ST_BUF_CONF_ES : fces_pkg::ST_BUF_LOAD2_ES,
                    4'h0);
            exp_err = (r != 0);
            if (r == 0) begin
                cmd(8'hD0, fces_pkg::ST_BUF_BUSY_ES, 4'h4);
                for (int i = 0; i < 11; i++) cmd(cmds[i], fces_pkg::ST_BUF_BUSY_ES, 4'h0);
                cmd(8'hD0, fces_pkg::ST_BUF_BUSY_ES, 4'h0);
                cmd(8'hB0, fces_pkg::ST_BUF_SUSP_ES, 4'h2);
                foreach (cmds[i]) cmd(cmds[i], fces_pkg::ST_BUF_SUSP_ES, 4'h0);
                cmd(8'hD0, fces_pkg::ST_BUF_BUSY_ES, 4'h1);
                done(ES);
            end else if (r == 1) begin
                cmd(cmds[$urandom_range(5)], ES, 4'h0);
            end else begin
                cmd(cmds[6 + $urandom_range(5)], RDY, 4'h0);
                // Ready must see suspension again to climb back
                erase_susp = 1'b1;
                u_host.idle(2);
                chk("suspend re-entry", 16'(ES), 16'(state));
            end
            exp_err = 1'b0;
            cmd(8'h50, ES, 4'h0);
        end
        // Lock setup in erase suspend: bad then every good confirm
        cmd(8'h60, fces_pkg::ST_LOCK_SETUP_ES, 4'h0);
        exp_lck = 1'b1;
        cmd(cmds[$urandom_range(10)], ES, 4'h0);
        exp_lck = 1'b0;
        cmd(8'h50, ES, 4'h0);
        foreach (okc[i]) begin
            cmd(8'h60, fces_pkg::ST_LOCK_SETUP_ES, 4'h0);
            cmd(okc[i], ES, 4'h0);
        end
        // Second reset without suspension, then factory programming
        // One idle edge first, so the last note is compared before reset
        u_host.idle(1);
        erase_susp = 1'b0;
        rst_n = 1'b0;
        u_host.idle(1);
        rst_n = 1'b1;
        chk("reset state", 16'(RDY), 16'(state));
        blk = 16'($urandom);
        cmd(8'h80, fces_pkg::ST_FBP_SETUP, 4'h0);
        exp_err = 1'b1;
        cmd(cmds[$urandom_range(11)], RDY, 4'h0);
        exp_err = 1'b0;
        cmd(8'h50, RDY, 4'h0);
        cmd(8'h80, fces_pkg::ST_FBP_SETUP, 4'h0);
        cmd(8'hD0, fces_pkg::ST_FBP_LOAD, 4'h0);
        for (int i = 0; i < 33; i++) fdat({8'($urandom), cmds[i % 12]});
        blk = ~blk;
        cmd(8'($urandom), RDY, 4'h0);
        u_host.idle(3);
        chk("notes left", 16'h0000, 16'(q.size()));
        test_done();
    end
endmodule
